/* File: shp_port.sv */
// module: spi register port with cold-start mode strap
`timescale 1ns/1ps
module shp_port
	import shp_pkg::*;
#(
	parameter int DATA_BITS = SHP_DATA_BITS,
	parameter int REG_COUNT = SHP_REG_COUNT
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic init_phase,
	input wire logic sclk_pin,
	input wire logic cs_pin,
	input wire logic mosi_pin,
	output logic miso_out,
	output logic miso_oe,
	output logic cs_pulldown_en,
	output logic i2c_mode,
	output logic i2c_addr_lsb,
	output logic [6:0] i2c_bus_addr,
	output logic scl_in,
	output logic sda_in,
	output logic port_active,
	output logic wr_strobe,
	output logic [5:0] wr_addr,
	output logic [DATA_BITS-1:0] wr_data
);
	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		shp_state_t state;
		logic mode;
		logic addr_lsb;
		logic [5:0] bit_cnt;
		logic frame_done;
		logic is_write;
		logic [5:0] addr;
		logic [DATA_BITS-1:0] rx;
		logic [DATA_BITS-1:0] tx;
		logic miso;
		logic wr_stb;
		logic [5:0] wr_a;
		logic [DATA_BITS-1:0] wr_d;
	} shp_port_state_t;

	shp_port_state_t st_reg;
	shp_port_state_t st_next;
	logic [DATA_BITS-1:0] regs_mem [REG_COUNT];
	// where in the frame the next rising edge falls
	typedef enum logic [1:0] {
		SHP_F_DIR = 2'h0,
		SHP_F_ADDR = 2'h1,
		SHP_F_NULL = 2'h2,
		SHP_F_DATA = 2'h3
	} shp_field_t;

	logic commit;
	logic [6:0] addr_shift;
	logic [5:0] cnt_end;
	shp_field_t rise_field;
	logic fall_drive;
	logic fall_last;

	shp_sync_if sy();

	shp_pin_sync u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.clk_en(clk_en),
		.sclk_pin(sclk_pin),
		.cs_pin(cs_pin),
		.mosi_pin(mosi_pin),
		.sy(sy)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bit class from the count of rises seen so far
	function automatic shp_field_t shp_field(input logic [5:0] cnt);
		shp_field_t f;
		if (cnt == 6'h00) begin
			f = SHP_F_DIR;
		end else if (cnt < SHP_ADDR_END) begin
			f = SHP_F_ADDR;
		end else if (cnt == SHP_ADDR_END) begin
			f = SHP_F_NULL;
		end else begin
			f = SHP_F_DATA;
		end
		return f;
	endfunction

	// a fall before a data-phase rise moves the next output bit
	function automatic logic shp_drives(input logic [5:0] cnt, input logic [5:0] last);
		logic d;
		d = 1'b0;
		if (shp_field(cnt) == SHP_F_DATA) begin
			d = (cnt != last);
		end
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next = st_reg;
		st_next.wr_stb = 1'b0;
		commit = 1'b0;
		addr_shift = {st_reg.addr, sy.mosi};
		cnt_end = SHP_LAST_BIT + 6'h01;
		rise_field = shp_field(st_reg.bit_cnt);
		fall_drive = shp_drives(st_reg.bit_cnt, cnt_end);
		fall_last = (st_reg.bit_cnt == cnt_end);
		case (st_reg.state)
			SHP_ST_INIT: begin
				// strap followed while init runs, frozen at its end
				// init must outlast the two-flop lag by a cycle or two
				if (init_phase) begin
					st_next.mode = sy.cs ? SHP_MODE_I2C : SHP_MODE_SPI;
					st_next.addr_lsb = sy.mosi;
				end else if (st_reg.mode == SHP_MODE_I2C) begin
					st_next.state = SHP_ST_I2C;
				end else begin
					st_next.state = SHP_ST_SPI;
				end
			end
			SHP_ST_SPI: begin
				if (!sy.cs) begin
					// partial frame dropped, toggle re-arms
					st_next.bit_cnt = '0;
					st_next.frame_done = 1'b0;
				end else if (!st_reg.frame_done) begin
					if (sy.sclk_rise && !fall_last) begin
						case (rise_field)
							SHP_F_DIR: begin
								st_next.is_write = sy.mosi;
							end
							SHP_F_ADDR: begin
								st_next.addr = addr_shift[5:0];
							end
							SHP_F_NULL: begin
								// null bit gives the lookup a whole bit time
								st_next.tx = regs_mem[st_reg.addr];
							end
							default: begin
								st_next.rx = {st_reg.rx[DATA_BITS-2:0], sy.mosi};
							end
						endcase
						st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
					end
					if (sy.sclk_fall && fall_drive) begin
						st_next.miso = st_reg.tx[DATA_BITS-1];
						st_next.tx = {st_reg.tx[DATA_BITS-2:0], 1'b0};
					end
					if (sy.sclk_fall && fall_last) begin
						// once per frame; a read leaves the map alone
						st_next.frame_done = 1'b1;
						st_next.miso = 1'b0;
						if (st_reg.is_write) begin
							commit = 1'b1;
							st_next.wr_stb = 1'b1;
							st_next.wr_a = st_reg.addr;
							st_next.wr_d = st_reg.rx;
						end
					end
				end
			end
			SHP_ST_I2C: begin
				// bus engine sits outside; only the strap is kept here
				st_next.bit_cnt = '0;
			end
			default: begin
				st_next.state = SHP_ST_INIT;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.state <= SHP_ST_INIT;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// whole map kept: simpler than decoding a sparse set
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_mem[i] <= DATA_BITS'(SHP_REG_RESET);
			end
		end else if (clk_en && commit) begin
			regs_mem[st_reg.addr] <= st_reg.rx;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign port_active = (st_reg.state == SHP_ST_SPI) || (st_reg.state == SHP_ST_I2C);
	assign i2c_mode = (st_reg.state == SHP_ST_I2C);

	assign i2c_addr_lsb = st_reg.addr_lsb;
	assign i2c_bus_addr = {SHP_I2C_ADDR_BASE[6:1], st_reg.addr_lsb};

	// weak pull-down stays on until the port enters i2c mode at the end of init
	assign cs_pulldown_en = (st_reg.state != SHP_ST_I2C);

	// clock pin reused as scl
	assign scl_in = i2c_mode ? sy.sclk : 1'b1;
	// no sda receive path at this level, released line reads high
	assign sda_in = 1'b1;

	// floats while chip select is low
	assign miso_oe = (st_reg.state == SHP_ST_SPI) && sy.cs;
	assign miso_out = st_reg.miso;

	assign wr_strobe = st_reg.wr_stb;
	assign wr_addr = st_reg.wr_a;
	assign wr_data = st_reg.wr_d;
endmodule

/* File: shp_pkg.sv */
// package: constants and types of the serial host port
// Operation
// - A low chip select level at cold start selects the spi mode, and the pin then acts as chip select.
// - A chip select tied high at cold start selects the i2c mode, and the pin does nothing else.
// - In i2c mode the clock pin carries scl and the data output pin carries sda; here sda_in is tied high and the data output is not driven.
// - In i2c mode the board straps the data input pin, and its level picks one of two bus addresses.
// - The chip select level is sampled and held during cold start initialization, before the port starts.
// - The chip select pin has a weak pull-down, so an unpowered host leads to spi mode.
// - Each spi frame is 32 bits: direction bit, 6 address bits, one null bit, 24 data bits.
// - The port decodes 64 addresses of 24 data bits, and not every address need exist.
// - The direction bit comes first (one writes, zero reads), the address is msb first, and a read changes nothing.
// - Input bits are sampled on the rising clock edge and the 24 output bits change on the falling edge.
// - A write commits at the falling edge of the 32nd clock, and the frame shifts out the old data of that address.
// - Chip select is active high for the whole frame, must toggle between frames, and the output floats while it is low.
package shp_pkg;
	localparam int SHP_FRAME_BITS = 32;
	localparam int SHP_ADDR_BITS = 6;
	localparam int SHP_DATA_BITS = 24;
	localparam int SHP_REG_COUNT = 64;
	localparam logic [5:0] SHP_ADDR_END = 6'h07;
	localparam logic [5:0] SHP_DATA_START = 6'h08;
	localparam logic [5:0] SHP_LAST_BIT = 6'h1F;
	localparam logic [6:0] SHP_I2C_ADDR_BASE = 7'h08;
	localparam logic [SHP_DATA_BITS-1:0] SHP_REG_RESET = 24'h000000;
	localparam logic SHP_MODE_SPI = 1'b0;
	localparam logic SHP_MODE_I2C = 1'b1;

	typedef enum logic [2:0] {
		SHP_ST_INIT = 3'b001,
		SHP_ST_SPI = 3'b010,
		SHP_ST_I2C = 3'b100
	} shp_state_t;
endpackage

/* File: shp_sync_if.sv */
// interface: synchronised pin levels and edges between the port modules
`timescale 1ns/1ps
interface shp_sync_if;
	logic sclk;
	logic sclk_rise;
	logic sclk_fall;
	logic cs;
	logic cs_fall;
	logic mosi;
	modport src (output sclk, sclk_rise, sclk_fall, cs, cs_fall, mosi);
	modport dst (input sclk, sclk_rise, sclk_fall, cs, cs_fall, mosi);
endinterface

/* File: shp_pin_sync.sv */
// module: two-flop synchronisers and edge finders for the port pins
`timescale 1ns/1ps
module shp_pin_sync
	import shp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic sclk_pin,
	input wire logic cs_pin,
	input wire logic mosi_pin,
	shp_sync_if.src sy
);
	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] stab;
		logic [1:0] prev;
	} shp_sync_state_t;

	shp_sync_state_t st_reg;
	shp_sync_state_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.meta = {sclk_pin, cs_pin, mosi_pin};
		st_next.stab = st_reg.meta;
		st_next.prev = st_reg.stab[2:1];
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_reg <= '0;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// edges only from stable copies, never the first flop
	assign sy.sclk = st_reg.stab[2];
	assign sy.cs = st_reg.stab[1];
	assign sy.mosi = st_reg.stab[0];
	assign sy.sclk_rise = clk_en & st_reg.stab[2] & ~st_reg.prev[1];
	assign sy.sclk_fall = clk_en & ~st_reg.stab[2] & st_reg.prev[1];
	assign sy.cs_fall = clk_en & ~st_reg.stab[1] & st_reg.prev[0];
endmodule

/* File: shp_port_asserts.sv */
// checker: port rules seen at the shp_port pins
`timescale 1ns/1ps
module shp_port_asserts
	import shp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic init_phase,
	input wire logic sclk_pin,
	input wire logic cs_pin,
	input wire logic miso_oe,
	input wire logic cs_pulldown_en,
	input wire logic i2c_mode,
	input wire logic [6:0] i2c_bus_addr,
	input wire logic i2c_addr_lsb,
	input wire logic scl_in,
	input wire logic port_active,
	input wire logic wr_strobe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence cs_idle;
		!cs_pin [*4];
	endsequence
	a_oe_cs_low: assert property (cs_idle |-> !miso_oe || i2c_mode)
		else $error("data output driven with chip select low");
	a_mode_held: assert property (port_active && $past(port_active) |-> $stable(i2c_mode))
		else $error("mode changed while active");
	a_pulldown_mode: assert property (port_active |-> cs_pulldown_en == !i2c_mode)
		else $error("pull-down wrong for mode");
	a_bus_addr: assert property (i2c_mode |-> i2c_bus_addr == (SHP_I2C_ADDR_BASE | i2c_addr_lsb))
		else $error("bus address wrong");
	a_scl_follow: assert property (i2c_mode && $rose(sclk_pin) |-> ##[1:4] scl_in)
		else $error("scl does not follow clock pin");
	a_strobe_spi: assert property (wr_strobe |-> !i2c_mode && port_active)
		else $error("write outside spi mode");
	a_init_quiet: assert property (init_phase |-> !port_active && !wr_strobe)
		else $error("port active during init");
	a_strobe_pulse: assert property (wr_strobe |=> !wr_strobe)
		else $error("write strobe too long");
endmodule
bind shp_port shp_port_asserts u_chk (.*);

/* File: shp_host_model.sv */
// partner: spi host that frames words on the port pins
`timescale 1ns/1ps
module shp_host_model (
	input wire logic clk_sys,
	input wire logic miso_out,
	output logic sclk_pin,
	output logic cs_pin,
	output logic mosi_pin
);
	initial {sclk_pin, cs_pin, mosi_pin} = 3'b000;
	// clock stands still between frames; idle data inverts
	task automatic frame(input logic [31:0] w, input int n, output logic [23:0] rd);
		cs_pin = 1;
		for (int i = 31; i > 31 - n; i--) begin
			mosi_pin = w[i];
			repeat (4) @(negedge clk_sys);
			sclk_pin = 1;
			if (i < 24) rd[i] = miso_out;
			repeat (4) @(negedge clk_sys);
			sclk_pin = 0;
		end
		repeat (4) @(negedge clk_sys);
		cs_pin = 0;
		mosi_pin = ~mosi_pin;
		repeat (8) @(negedge clk_sys);
	endtask
endmodule

/* File: serial_host_port_config_tb_top.sv */
// testbench: spi frames, abort and i2c strap
`timescale 1ns/1ps
module serial_host_port_config_tb_top;
	import shp_pkg::*;
	logic clk_sys = 0, rst = 1, init_phase = 1, s_cs = 0, s_a0 = 0;
	logic sclk, h_cs, h_mosi, miso, oe, pd, i2c, a0, scl, wr, act, sda;
	logic [6:0] bus;
	logic [5:0] wa, w_addr;
	logic [23:0] wd, w_data, rd;
	int fails = 0, cmp_count = 0, n_wr = 0;
	always #25 clk_sys = ~clk_sys;
	shp_host_model u_host (.clk_sys(clk_sys), .miso_out(miso), .sclk_pin(sclk),
		.cs_pin(h_cs), .mosi_pin(h_mosi));
	shp_port u_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .init_phase(init_phase),
		.sclk_pin(sclk), .cs_pin(h_cs | s_cs), .mosi_pin(h_mosi | s_a0), .miso_out(miso),
		.miso_oe(oe), .cs_pulldown_en(pd), .i2c_mode(i2c), .i2c_addr_lsb(a0),
		.i2c_bus_addr(bus), .scl_in(scl), .sda_in(sda), .port_active(act), .wr_strobe(wr),
		.wr_addr(wa), .wr_data(wd));
	always @(negedge clk_sys) if (wr === 1'b1) begin
		n_wr++;
		{w_addr, w_data} = {wa, wd};
	end
	task check(input string nm, input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %s exp %h got %h", nm, exp, got);
		end
	endtask
	task close_out;
		$display("checks %0d fails %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task cold(input logic cs_s, a0_s);
		@(negedge clk_sys);
		{rst, init_phase, s_cs, s_a0} = {2'b11, cs_s, a0_s};
		repeat (5) @(negedge clk_sys);
		rst = 0;
		repeat (4) @(negedge clk_sys);
		init_phase = 0;
		repeat (4) @(negedge clk_sys);
	endtask
	////////////////////////////////
	task t_spi;
		cold(0, 0);
		check("mode", {i2c, pd}, 2'b01);
		check("act", act, 1'b1);
		u_host.frame({1'b1, 6'h3F, 1'b0, 24'hA5C3F0}, 32, rd);
		check("oe", oe, 1'b0);
		check("wr", {n_wr[1:0], w_addr, w_data}, {2'd1, 6'h3F, 24'hA5C3F0});
		check("old", rd, SHP_REG_RESET);
		u_host.frame({1'b0, 6'h3F, 1'b0, 24'h5A5A5A}, 32, rd);
		check("rd", {n_wr[1:0], rd}, {2'd1, 24'hA5C3F0});
		u_host.frame({1'b1, 6'h3F, 1'b0, 24'h000001}, 16, rd);
		u_host.frame({1'b1, 6'h01, 1'b0, 24'h00FF00}, 32, rd);
		check("abort", {n_wr[1:0], w_addr, w_data}, {2'd2, 6'h01, 24'h00FF00});
	endtask
	task t_i2c;
		cold(1, 1);
		check("i2c", {i2c, pd, a0, bus}, {3'b101, 7'h09});
		u_host.frame(32'h0, 8, rd);
		check("nowr", n_wr, 2);
		check("scl", scl, 1'b0);
		check("sda", sda, 1'b1);
	endtask
	initial begin
		t_spi;
		t_i2c;
		close_out;
	end
	initial begin
		#1000000;
		fails++;
		close_out;
	end
endmodule
